// ---- shared/pmc_pkg.sv ----
// Shared constants and types for the power mode controller.
// Assumes a 32-bit APB master and a single 250 MHz clock domain.
package pmc_pkg;

   // Register indices; byte address is four times the index
   localparam logic [23:0] IDX_CTRL = 24'hfffc60;
   localparam logic [23:0] IDX_STAT = 24'hfffc62;
   localparam logic [23:0] IDX_CRC = 24'hfffc64;
   localparam logic [31:0] ADDR_CTRL = {6'h00, IDX_CTRL, 2'h0};
   localparam logic [31:0] ADDR_STAT = {6'h00, IDX_STAT, 2'h0};
   localparam logic [31:0] ADDR_CRC = {6'h00, IDX_CRC, 2'h0};

   // Decoded register selects
   localparam logic [1:0] SEL_CTRL = 2'h0;
   localparam logic [1:0] SEL_STAT = 2'h1;
   localparam logic [1:0] SEL_CRC = 2'h2;
   localparam logic [1:0] SEL_NONE = 2'h3;

   // Reset values and field positions
   localparam logic [7:0] CTRL_RST = 8'h00;
   // PLL starts off, in step with the power-down bit's reset value
   localparam logic [4:0] CLK_CTL_RST = 5'h10;
   localparam logic PLL_PD_RST = 1'h1;
   localparam int PLL_PD_BIT = 0;
   localparam int CTRL_W = 8;

   // Number of asynchronous status pins brought through synchronisers
   localparam int SYNC_W = 4;

   // Control register, bit 7 down to bit 0
   typedef struct packed {
      logic pll_hw_gate;
      logic osc_hw_gate;
      logic pll_disable;
      logic osc_disable;
      logic wait_before_entry;
      logic halt;
      logic idle;
      logic power_save_request;
   } pmc_ctrl_t;

   // Pins from the link controller and clock monitors
   typedef struct packed {
      logic link_sleep;
      logic pll_clock_stable;
      logic main_clock_stable;
      logic low_clock_stable;
   } pmc_pins_t;

   // Clock steering outputs
   typedef struct packed {
      logic osc_enable;
      logic pll_enable;
      logic sys_clk_slow;
      logic sys_clk_stop;
      logic slow_clk_stop;
   } pmc_clk_ctl_t;

   typedef enum logic [6:0] {
      ST_ACTIVE = 7'h01,
      ST_PSAVE = 7'h02,
      ST_IDLE = 7'h04,
      ST_HALT_ENTER = 7'h08,
      ST_HALT = 7'h10,
      ST_WAKE_OSC = 7'h20,
      ST_WAKE_PLL = 7'h40
   } pmc_state_t;

endpackage

// ---- hdl/pmc_sync.sv ----
// Two-stage synchroniser for the asynchronous status pins.
// Assumes each pin is a slow level; no pulse is shorter than a few clocks.
`timescale 1ns/1ns
module pmc_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Pins in, synchronised levels out
   input wire pmc_pkg::pmc_pins_t pins_in,
   output pmc_pkg::pmc_pins_t pins_out
);
   pmc_pkg::pmc_pins_t meta_reg;
   pmc_pkg::pmc_pins_t sync_reg;

   // First stage is read by the second stage only
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= pmc_pkg::pmc_pins_t'(4'h0);
         sync_reg <= pmc_pkg::pmc_pins_t'(4'h0);
      end else begin
         meta_reg <= pins_in;
         sync_reg <= meta_reg;
      end
   end

   assign pins_out = sync_reg;
endmodule // pmc_sync

// ---- hdl/pmc_clock_gate.sv ----
// Decides oscillator and PLL enables from the power mode and control bits.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ns
module pmc_clock_gate (
   // Mode and control
   input wire pmc_pkg::pmc_state_t state,
   input wire pmc_pkg::pmc_ctrl_t ctrl,
   input wire logic pll_power_down,
   input wire logic link_sleep,
   // Enables
   output logic osc_en,
   output logic pll_en
);
   always_comb begin
      osc_en = 1'h1;
      pll_en = !pll_power_down;
      unique case (state)
         pmc_pkg::ST_ACTIVE, pmc_pkg::ST_HALT_ENTER: begin
            osc_en = 1'h1;
            pll_en = !pll_power_down;
         end
         pmc_pkg::ST_PSAVE, pmc_pkg::ST_IDLE: begin
            // Idle relies on software having set both disable bits first
            osc_en = !(ctrl.osc_disable || (ctrl.osc_hw_gate && link_sleep));
            pll_en = !(pll_power_down || ctrl.pll_disable ||
                       (ctrl.pll_hw_gate && link_sleep));
         end
         pmc_pkg::ST_HALT: begin
            osc_en = 1'h0;
            pll_en = 1'h0;
         end
         pmc_pkg::ST_WAKE_OSC: begin
            osc_en = !ctrl.osc_disable;
            // PLL keeps running unless disabled; no needless restart on wake
            pll_en = !(ctrl.pll_disable || pll_power_down);
         end
         pmc_pkg::ST_WAKE_PLL: begin
            osc_en = 1'h1;
            pll_en = !(ctrl.pll_disable || pll_power_down);
         end
         default: begin
            osc_en = 1'h1;
            pll_en = !pll_power_down;
         end
      endcase
   end
endmodule // pmc_clock_gate

// ---- hdl/pmc_power_mode_manager.sv ----
// Power mode controller: APB registers, mode state machine, clock steering.
// Assumes wait_exec and wake_event come from logic on clk; clock monitor
// and link sleep pins are asynchronous and are synchronised here.
//
// How it works
// - Power Save runs the system clock from the slow clock.
// - Idle stops the system clock; slow clock and its users keep running.
// - Idle entry is accepted only from Active.
// - Halt stops all clocks, oscillator and PLL; state is kept.
// - Halt entry is accepted only from Active.
// - Hardware gate bits drop oscillator or PLL while the link sleeps in Power Save or Idle.
// - Disable bits force the source off in Power Save regardless.
// - Active forces oscillator on and PLL on unless powered down, Halt forces both off.
// - PLL power-down turns the PLL off in every mode, oscillator untouched.
// - Control register: eight read/write bits, cleared at reset.
// - Immediate Power Save request; the bit reads one after switching.
// - With wait-before-entry set, Power Save waits for a WAIT instruction.
// - Software or a wake-up clears the power save request bit.
// - Idle entered at next WAIT when wait-before-entry is set; wake-up clears the idle bit.
// - Halt at next WAIT when wait-before-entry is set: system clock stops first, then PLL and oscillator.
// - Wake-up from Halt restarts oscillator; halt bit clears once stable.
// - With deferred entry, sources go off only after the mode is entered.
// - Oscillator disable acts in Power Save; wake-up clears it.
// - PLL disable acts in Power Save; wake-up clears it.
// - Oscillator hardware gate acts in Power Save and Idle; cleared on Active.
// - PLL hardware gate acts in Power Save and Idle; cleared on Active.
// - Wake-up: clear osc disable, wait main stable, clear PLL disable, wait PLL.
// - A switch waits until the clock it needs reports stable.
`timescale 1ns/1ns
module pmc_power_mode_manager (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // CPU and wake-up logic
   input wire logic wait_exec,
   input wire logic wake_event,
   // Asynchronous status pins
   input wire pmc_pkg::pmc_pins_t clk_pins,
   // Clock steering and mode
   output pmc_pkg::pmc_clk_ctl_t clk_ctl,
   output pmc_pkg::pmc_state_t power_mode
);

   function automatic logic [1:0] decode(input logic [31:0] addr);
      logic [1:0] sel;
      sel = pmc_pkg::SEL_NONE;
      if (addr == pmc_pkg::ADDR_CTRL) begin
         sel = pmc_pkg::SEL_CTRL;
      end else if (addr == pmc_pkg::ADDR_STAT) begin
         sel = pmc_pkg::SEL_STAT;
      end else if (addr == pmc_pkg::ADDR_CRC) begin
         sel = pmc_pkg::SEL_CRC;
      end
      return sel;
   endfunction

   pmc_pkg::pmc_pins_t pins_s;
   pmc_pkg::pmc_state_t state_reg;
   pmc_pkg::pmc_state_t state_next;
   pmc_pkg::pmc_ctrl_t ctrl_reg;
   pmc_pkg::pmc_ctrl_t ctrl_next;
   pmc_pkg::pmc_ctrl_t wctrl;
   pmc_pkg::pmc_clk_ctl_t clk_ctl_reg;
   pmc_pkg::pmc_clk_ctl_t clk_ctl_next;
   logic pll_pd_reg;
   logic pll_pd_next;
   logic ps_pending_reg;
   logic ps_pending_next;
   logic wait_armed_reg;
   logic wait_armed_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic [1:0] sel;
   logic access;
   logic wr;
   logic pll_ok;
   logic pll_ready;
   logic osc_en;
   logic pll_en;
   logic [7:0] status;

   pmc_sync u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .pins_in(clk_pins),
      .pins_out(pins_s)
   );

   // Gate decisions use the current mode, so a deferred request never
   // turns a source off before the mode is really entered
   pmc_clock_gate u_gate (
      .state(state_reg),
      .ctrl(ctrl_reg),
      .pll_power_down(pll_pd_reg),
      .link_sleep(pins_s.link_sleep),
      .osc_en(osc_en),
      .pll_en(pll_en)
   );

   // A disabled PLL counts as stable so it never blocks a switch
   assign pll_ok = pins_s.pll_clock_stable || !clk_ctl_reg.pll_enable;
   assign status = {5'h00, pll_ok, pins_s.main_clock_stable, pins_s.low_clock_stable};
   // Wake waits on the real monitor once the PLL is wanted; the registered
   // enable lags a cycle, so it must not count as disabled
   assign pll_ready = !pll_en || (clk_ctl_reg.pll_enable && pins_s.pll_clock_stable);

   // APB: zero wait states, data prepared in the setup cycle
   assign sel = decode(paddr);
   assign access = psel && penable;
   assign pready = access;
   assign pslverr = access && (sel == pmc_pkg::SEL_NONE);
   assign wr = access && pwrite && (sel != pmc_pkg::SEL_NONE);
   assign wctrl = pmc_pkg::pmc_ctrl_t'(pwdata[pmc_pkg::CTRL_W-1:0]);
   assign prdata = prdata_reg;

   always_comb begin
      prdata_next = prdata_reg;
      if (psel && !penable && !pwrite) begin
         unique case (sel)
            pmc_pkg::SEL_CTRL: prdata_next = {24'h000000, ctrl_reg};
            pmc_pkg::SEL_STAT: prdata_next = {24'h000000, status};
            pmc_pkg::SEL_CRC: prdata_next = {31'h00000000, pll_pd_reg};
            pmc_pkg::SEL_NONE: prdata_next = 32'h00000000;
         endcase
      end
   end

   always_comb begin
      state_next = state_reg;
      ctrl_next = ctrl_reg;
      pll_pd_next = pll_pd_reg;
      ps_pending_next = ps_pending_reg;
      wait_armed_next = wait_armed_reg;

      // Software writes first, so hardware updates below win a tie
      if (wr && sel == pmc_pkg::SEL_CRC) begin
         pll_pd_next = pwdata[pmc_pkg::PLL_PD_BIT];
      end
      if (wr && sel == pmc_pkg::SEL_CTRL) begin
         ctrl_next.pll_hw_gate = wctrl.pll_hw_gate;
         ctrl_next.osc_hw_gate = wctrl.osc_hw_gate;
         ctrl_next.pll_disable = wctrl.pll_disable;
         ctrl_next.osc_disable = wctrl.osc_disable;
         ctrl_next.wait_before_entry = wctrl.wait_before_entry;
         if (state_reg == pmc_pkg::ST_ACTIVE) begin
            if (wctrl.power_save_request && !ctrl_reg.power_save_request) begin
               if (wctrl.wait_before_entry) begin
                  ctrl_next.power_save_request = 1'h1;
               end else begin
                  ps_pending_next = 1'h1;
               end
            end else if (!wctrl.power_save_request) begin
               ctrl_next.power_save_request = 1'h0;
               ps_pending_next = 1'h0;
            end
            ctrl_next.idle = wctrl.idle;
            ctrl_next.halt = wctrl.halt;
         end else if (state_reg == pmc_pkg::ST_PSAVE && !wctrl.power_save_request) begin
            // Bit stays set until Active is reached
            state_next = pmc_pkg::ST_WAKE_OSC;
         end
      end

      unique case (state_reg)
         pmc_pkg::ST_ACTIVE: begin
            if (wait_exec && ctrl_next.wait_before_entry &&
                (ctrl_next.halt || ctrl_next.idle || ctrl_next.power_save_request)) begin
               wait_armed_next = 1'h1;
            end
            // Low-power modes need a stable slow clock
            if (ps_pending_reg && pins_s.low_clock_stable) begin
               state_next = pmc_pkg::ST_PSAVE;
               ctrl_next.power_save_request = 1'h1;
               ps_pending_next = 1'h0;
            end else if (wait_armed_reg && pins_s.low_clock_stable) begin
               wait_armed_next = 1'h0;
               if (ctrl_reg.halt) begin
                  state_next = pmc_pkg::ST_HALT_ENTER;
               end else if (ctrl_reg.idle) begin
                  state_next = pmc_pkg::ST_IDLE;
               end else if (ctrl_reg.power_save_request) begin
                  state_next = pmc_pkg::ST_PSAVE;
               end
            end
         end
         pmc_pkg::ST_PSAVE, pmc_pkg::ST_IDLE, pmc_pkg::ST_HALT: begin
            if (wake_event) begin
               ctrl_next.osc_disable = 1'h0;
               ctrl_next.power_save_request = 1'h0;
               ctrl_next.idle = 1'h0;
               state_next = pmc_pkg::ST_WAKE_OSC;
            end
         end
         pmc_pkg::ST_HALT_ENTER: begin
            state_next = pmc_pkg::ST_HALT;
         end
         pmc_pkg::ST_WAKE_OSC: begin
            if (pins_s.main_clock_stable) begin
               ctrl_next.halt = 1'h0;
               ctrl_next.pll_disable = 1'h0;
               state_next = pmc_pkg::ST_WAKE_PLL;
            end
         end
         pmc_pkg::ST_WAKE_PLL: begin
            if (pll_ready) begin
               ctrl_next.power_save_request = 1'h0;
               ctrl_next.osc_hw_gate = 1'h0;
               ctrl_next.pll_hw_gate = 1'h0;
               state_next = pmc_pkg::ST_ACTIVE;
            end
         end
         default: begin
            state_next = pmc_pkg::ST_ACTIVE;
         end
      endcase
   end

   always_comb begin
      clk_ctl_next.osc_enable = osc_en;
      clk_ctl_next.pll_enable = pll_en;
      clk_ctl_next.sys_clk_slow = (state_reg == pmc_pkg::ST_PSAVE) ||
                                  (state_reg == pmc_pkg::ST_WAKE_OSC) ||
                                  (state_reg == pmc_pkg::ST_WAKE_PLL);
      clk_ctl_next.sys_clk_stop = (state_reg == pmc_pkg::ST_IDLE) ||
                                  (state_reg == pmc_pkg::ST_HALT_ENTER) ||
                                  (state_reg == pmc_pkg::ST_HALT);
      clk_ctl_next.slow_clk_stop = (state_reg == pmc_pkg::ST_HALT);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= pmc_pkg::ST_ACTIVE;
         ctrl_reg <= pmc_pkg::pmc_ctrl_t'(pmc_pkg::CTRL_RST);
         pll_pd_reg <= pmc_pkg::PLL_PD_RST;
         ps_pending_reg <= 1'h0;
         wait_armed_reg <= 1'h0;
         prdata_reg <= 32'h00000000;
         clk_ctl_reg <= pmc_pkg::pmc_clk_ctl_t'(pmc_pkg::CLK_CTL_RST);
      end else begin
         state_reg <= state_next;
         ctrl_reg <= ctrl_next;
         pll_pd_reg <= pll_pd_next;
         ps_pending_reg <= ps_pending_next;
         wait_armed_reg <= wait_armed_next;
         prdata_reg <= prdata_next;
         clk_ctl_reg <= clk_ctl_next;
      end
   end

   assign clk_ctl = clk_ctl_reg;
   assign power_mode = state_reg;

   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   idle_from_active_a: assert property (
      (state_reg == pmc_pkg::ST_IDLE) && ($past(state_reg) != pmc_pkg::ST_IDLE)
      |-> ($past(state_reg) == pmc_pkg::ST_ACTIVE))
      else $error("Idle entered from a mode other than Active");

   halt_from_active_a: assert property (
      $rose(state_reg == pmc_pkg::ST_HALT_ENTER) |-> ($past(state_reg) == pmc_pkg::ST_ACTIVE))
      else $error("Halt entered from a mode other than Active");

   halt_order_a: assert property (
      (state_reg == pmc_pkg::ST_HALT_ENTER)
      |=> clk_ctl.sys_clk_stop && clk_ctl.osc_enable && (state_reg == pmc_pkg::ST_HALT)
      ##1 !clk_ctl.osc_enable)
      else $error("Halt entry did not stop system clock before oscillator");

   halt_clocks_off_a: assert property (
      (state_reg == pmc_pkg::ST_HALT)
      |=> !clk_ctl.osc_enable && !clk_ctl.pll_enable && clk_ctl.slow_clk_stop)
      else $error("A clock is still running in Halt");

   active_osc_on_a: assert property (
      (state_reg == pmc_pkg::ST_ACTIVE) |=> clk_ctl.osc_enable)
      else $error("Oscillator off in Active");

   pll_power_down_a: assert property (
      pll_pd_reg |=> !clk_ctl.pll_enable)
      else $error("PLL running while powered down");

   psave_slow_clk_a: assert property (
      (state_reg == pmc_pkg::ST_PSAVE) |=> clk_ctl.sys_clk_slow && !clk_ctl.sys_clk_stop)
      else $error("Power Save not on slow clock");

   idle_clk_stop_a: assert property (
      (state_reg == pmc_pkg::ST_IDLE) |=> clk_ctl.sys_clk_stop && !clk_ctl.slow_clk_stop)
      else $error("Idle clock steering wrong");

   disable_override_a: assert property (
      (state_reg == pmc_pkg::ST_PSAVE) && ctrl_reg.osc_disable |=> !clk_ctl.osc_enable)
      else $error("Oscillator disable ignored in Power Save");

   hw_gate_sleep_a: assert property (
      (state_reg == pmc_pkg::ST_PSAVE) && ctrl_reg.pll_hw_gate && pins_s.link_sleep
      |=> !clk_ctl.pll_enable)
      else $error("PLL not gated while link sleeps");

   wake_clears_a: assert property (
      (state_reg inside {pmc_pkg::ST_PSAVE, pmc_pkg::ST_IDLE, pmc_pkg::ST_HALT}) && wake_event
      |=> !ctrl_reg.osc_disable && !ctrl_reg.idle && (state_reg == pmc_pkg::ST_WAKE_OSC))
      else $error("Wake-up did not clear bits or start the sequence");

   wake_holds_a: assert property (
      (state_reg == pmc_pkg::ST_WAKE_OSC) && !pins_s.main_clock_stable
      |=> (state_reg == pmc_pkg::ST_WAKE_OSC) && $stable(ctrl_reg.halt))
      else $error("Switch went ahead without a stable main clock");

   active_gate_clear_a: assert property (
      $rose(state_reg == pmc_pkg::ST_ACTIVE) |-> !ctrl_reg.osc_hw_gate && !ctrl_reg.pll_hw_gate)
      else $error("Hardware gate bits not cleared on Active");

   wake_pll_wait_a: assert property (
      (state_reg == pmc_pkg::ST_WAKE_PLL) && pll_en && !pins_s.pll_clock_stable
      |=> (state_reg == pmc_pkg::ST_WAKE_PLL))
      else $error("Active reached before the PLL was stable");

   low_clock_holdoff_a: assert property (
      (state_reg == pmc_pkg::ST_ACTIVE) && !pins_s.low_clock_stable
      |=> (state_reg == pmc_pkg::ST_ACTIVE))
      else $error("Low-power mode entered without a stable slow clock");

   psave_entry_c: cover property (
      (state_reg == pmc_pkg::ST_ACTIVE) ##1 (state_reg == pmc_pkg::ST_PSAVE));
   idle_wake_c: cover property (
      (state_reg == pmc_pkg::ST_IDLE) ##1 (state_reg == pmc_pkg::ST_WAKE_OSC));
   halt_wake_c: cover property (
      (state_reg == pmc_pkg::ST_HALT) ##1 (state_reg == pmc_pkg::ST_WAKE_OSC));
   wake_done_c: cover property (
      (state_reg == pmc_pkg::ST_WAKE_PLL) ##1 (state_reg == pmc_pkg::ST_ACTIVE));

endmodule // pmc_power_mode_manager

// ---- verification/pmc_far_model.sv ----
// Far-side model: clock monitors and the link controller's sleep level.
// Assumes stable flags rise a fixed delay after an enable and drop at once.
`timescale 1ns/1ns
module pmc_far_model #(
   parameter int STABLE_DLY = 12
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Bench controls and controller enables
   input wire logic low_ok,
   input wire logic sleep_req,
   input wire pmc_pkg::pmc_clk_ctl_t clk_ctl,
   // Status pins
   output pmc_pkg::pmc_pins_t pins
);
   int osc_cnt;
   int pll_cnt;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         osc_cnt <= 0;
         pll_cnt <= 0;
      end else begin
         // A source switched off is unstable at once, never stale
         osc_cnt <= !clk_ctl.osc_enable ? 0 : (osc_cnt < STABLE_DLY) ? osc_cnt + 1 : osc_cnt;
         pll_cnt <= !clk_ctl.pll_enable ? 0 : (pll_cnt < STABLE_DLY) ? pll_cnt + 1 : pll_cnt;
      end
   end
   assign pins.link_sleep = sleep_req;
   assign pins.pll_clock_stable = (pll_cnt >= STABLE_DLY);
   assign pins.main_clock_stable = (osc_cnt >= STABLE_DLY);
   assign pins.low_clock_stable = low_ok;
endmodule // pmc_far_model

// ---- verification/tb_pmc_power_mode_manager.sv ----
// Self-checking bench for the power mode controller over APB.
// Assumes the far-side model supplies clock status and the sleep level.
`timescale 1ns/1ns
module tb_pmc_power_mode_manager;
   logic clk, rst_b, psel, penable, pwrite, pready, pslverr, wait_exec, wake_event;
   logic low_ok, sleep_req, rerr;
   logic [31:0] paddr, pwdata, prdata, rdat;
   pmc_pkg::pmc_pins_t clk_pins;
   pmc_pkg::pmc_clk_ctl_t clk_ctl;
   pmc_pkg::pmc_state_t power_mode;
   int miscompares = 0;
   int tests_run = 0;

   pmc_power_mode_manager pmc_power_mode_manager_inst (.clk(clk), .rst_b(rst_b),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .wait_exec(wait_exec),
      .wake_event(wake_event), .clk_pins(clk_pins), .clk_ctl(clk_ctl),
      .power_mode(power_mode));
   pmc_far_model pmc_far_model_inst (.clk(clk), .rst_b(rst_b), .low_ok(low_ok),
      .sleep_req(sleep_req), .clk_ctl(clk_ctl), .pins(clk_pins));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic chk_clk(input logic [4:0] mask, input logic [4:0] exp);
      chk("clk_ctl", {27'h0, exp}, {27'h0, clk_ctl & mask});
   endtask

   task automatic chk_mode(input pmc_pkg::pmc_state_t m);
      chk("power_mode", {25'h0, m}, {25'h0, power_mode});
   endtask

   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) chk("pready", 32'h1, 32'h0);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk("prdata", exp, rdat);
   endtask

   task automatic pulse(input logic wk);
      @(posedge clk);
      if (wk) wake_event <= 1'b1;
      else wait_exec <= 1'b1;
      @(posedge clk);
      wake_event <= 1'b0;
      wait_exec <= 1'b0;
   endtask

   task automatic wait_mode(input pmc_pkg::pmc_state_t m);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (power_mode !== m && n < 200);
      chk_mode(m);
   endtask

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Generous bound; the sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      close_out;
   end

   initial begin
      {psel, penable, pwrite, wait_exec, wake_event, low_ok, sleep_req} = 7'h00;
      paddr = 32'h0;
      pwdata = 32'h0;
      rst_b = 1'b0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (20) @(negedge clk);
      chk_clk(5'h1f, 5'h10);
      rd(pmc_pkg::ADDR_STAT, 32'h6);
      rd(pmc_pkg::ADDR_CTRL, 32'h0);
      xfer(1'b0, 32'h0, 32'h0);
      chk("pslverr", 32'h1, {31'h0, rerr});
      xfer(1'b1, pmc_pkg::ADDR_CRC, 32'h0);
      xfer(1'b1, pmc_pkg::ADDR_CTRL, 32'hf8);
      rd(pmc_pkg::ADDR_CTRL, 32'hf8);
      chk_clk(5'h18, 5'h18);
      xfer(1'b1, pmc_pkg::ADDR_CTRL, 32'h0);
      // Immediate entry held off until the slow clock is stable
      xfer(1'b1, pmc_pkg::ADDR_CTRL, 32'h01);
      repeat (10) @(negedge clk);
      chk_mode(pmc_pkg::ST_ACTIVE);
      @(posedge clk) low_ok <= 1'b1;
      wait_mode(pmc_pkg::ST_PSAVE);
      rd(pmc_pkg::ADDR_CTRL, 32'h01);
      chk_clk(5'h04, 5'h04);
      xfer(1'b1, pmc_pkg::ADDR_CTRL, 32'hc1);
      @(posedge clk) sleep_req <= 1'b1;
      repeat (8) @(negedge clk);
      chk_clk(5'h18, 5'h00);
      @(posedge clk) sleep_req <= 1'b0;
      repeat (8) @(negedge clk);
      chk_clk(5'h18, 5'h18);
      pulse(1'b1);
      wait_mode(pmc_pkg::ST_ACTIVE);
      rd(pmc_pkg::ADDR_CTRL, 32'h0);
      // Deferred entry with the oscillator disabled
      xfer(1'b1, pmc_pkg::ADDR_CTRL, 32'h19);
      rd(pmc_pkg::ADDR_CTRL, 32'h19);
      chk_mode(pmc_pkg::ST_ACTIVE);
      chk_clk(5'h18, 5'h18);
      pulse(1'b0);
      wait_mode(pmc_pkg::ST_PSAVE);
      repeat (2) @(negedge clk);
      chk_clk(5'h18, 5'h08);
      xfer(1'b1, pmc_pkg::ADDR_CTRL, 32'h1f);
      pulse(1'b0);
      repeat (4) @(negedge clk);
      chk_mode(pmc_pkg::ST_PSAVE);
      rd(pmc_pkg::ADDR_CTRL, 32'h19);
      xfer(1'b1, pmc_pkg::ADDR_CTRL, 32'h08);
      wait_mode(pmc_pkg::ST_ACTIVE);
      rd(pmc_pkg::ADDR_CTRL, 32'h08);
      // Both disables set first, as software must
      xfer(1'b1, pmc_pkg::ADDR_CTRL, 32'h3a);
      pulse(1'b0);
      wait_mode(pmc_pkg::ST_IDLE);
      repeat (2) @(negedge clk);
      chk_clk(5'h1b, 5'h02);
      pulse(1'b1);
      wait_mode(pmc_pkg::ST_ACTIVE);
      rd(pmc_pkg::ADDR_CTRL, 32'h08);
      xfer(1'b1, pmc_pkg::ADDR_CTRL, 32'h3c);
      pulse(1'b0);
      wait_mode(pmc_pkg::ST_HALT);
      chk_clk(5'h12, 5'h12);
      repeat (2) @(negedge clk);
      chk_clk(5'h1b, 5'h03);
      pulse(1'b1);
      wait_mode(pmc_pkg::ST_WAKE_OSC);
      repeat (2) @(negedge clk);
      chk_clk(5'h10, 5'h10);
      rd(pmc_pkg::ADDR_CTRL, 32'h2c);
      wait_mode(pmc_pkg::ST_ACTIVE);
      rd(pmc_pkg::ADDR_CTRL, 32'h08);
      close_out;
   end
endmodule // tb_pmc_power_mode_manager
